// ==== right_deemph_3d_coeff_regs.v ====
/*
 Register bank holding the right-channel de-emphasis filter coefficients
 and the spatial (3-D) attenuation coefficient, eight bytes on page 1.
 Assumes the control-bus decoder on the same clock presents a page number,
 a 7-bit register address, a one-cycle write strobe and write data, and
 reads the byte on rd_data_o one cycle after it sets rd_en_i.
*/
`include "rdc_defs.vh"

module right_deemph_3d_coeff_regs (
	input  wire               clk_sys_i,
	input  wire               rst_i,
	input  wire        [7:0]  page_i,
	input  wire        [6:0]  addr_i,
	input  wire               wr_en_i,
	input  wire        [7:0]  wr_data_i,
	input  wire               rd_en_i,
	output wire        [7:0]  rd_data_o,
	output wire               rd_hit_o,
	output wire signed [15:0] numerator_tap_zero_o,
	output wire signed [15:0] numerator_tap_one_o,
	output wire signed [15:0] denominator_tap_one_o,
	output wire signed [15:0] spatial_atten_o
);
	// Slot numbers follow the address order, upper byte before lower byte
	localparam [2:0] SLOT_NUM0_HI  = 3'h0;
	localparam [2:0] SLOT_NUM0_LO  = 3'h1;
	localparam [2:0] SLOT_NUM1_HI  = 3'h2;
	localparam [2:0] SLOT_NUM1_LO  = 3'h3;
	localparam [2:0] SLOT_DEN1_HI  = 3'h4;
	localparam [2:0] SLOT_DEN1_LO  = 3'h5;
	localparam [2:0] SLOT_ATTEN_HI = 3'h6;
	localparam [2:0] SLOT_ATTEN_LO = 3'h7;

	reg  [7:0] rd_data_ff;
	reg        rd_hit_ff;
	reg  [7:0] nxt_rd_data;
	reg        nxt_rd_hit;
	reg        num0_hi_wr;
	reg        num0_lo_wr;
	reg        num1_hi_wr;
	reg        num1_lo_wr;
	reg        den1_hi_wr;
	reg        den1_lo_wr;
	reg        atten_hi_wr;
	reg        atten_lo_wr;
	wire       sel_ok;
	wire [2:0] sel_slot;
	wire       wr_take;
	wire       rd_take;
	wire [7:0] num0_hi_byte;
	wire [7:0] num0_lo_byte;
	wire [7:0] num1_hi_byte;
	wire [7:0] num1_lo_byte;
	wire [7:0] den1_hi_byte;
	wire [7:0] den1_lo_byte;
	wire [7:0] atten_hi_byte;
	wire [7:0] atten_lo_byte;

	// Address lies in this bank on the selected page
	function in_bank;
		input [7:0] page;
		input [6:0] addr;
		reg         page_ok;
		reg         low_ok;
		reg         high_ok;
		begin
			page_ok = (page == `RDC_PAGE);
			low_ok  = (addr >= `RDC_BASE_ADDR);
			high_ok = (addr <= `RDC_LAST_ADDR);
			in_bank = page_ok && low_ok && high_ok;
		end
	endfunction

	// Slot of an address; outside the bank the result is masked by in_bank,
	// so the default slot never reaches a register
	function [2:0] slot_of;
		input [6:0] addr;
		begin
			case (addr)
				`RDC_NUM0_HI_ADDR: begin
					slot_of = SLOT_NUM0_HI;
				end
				`RDC_NUM0_LO_ADDR: begin
					slot_of = SLOT_NUM0_LO;
				end
				`RDC_NUM1_HI_ADDR: begin
					slot_of = SLOT_NUM1_HI;
				end
				`RDC_NUM1_LO_ADDR: begin
					slot_of = SLOT_NUM1_LO;
				end
				`RDC_DEN1_HI_ADDR: begin
					slot_of = SLOT_DEN1_HI;
				end
				`RDC_DEN1_LO_ADDR: begin
					slot_of = SLOT_DEN1_LO;
				end
				`RDC_ATTEN_HI_ADDR: begin
					slot_of = SLOT_ATTEN_HI;
				end
				`RDC_ATTEN_LO_ADDR: begin
					slot_of = SLOT_ATTEN_LO;
				end
				default: begin
					slot_of = SLOT_NUM0_HI;
				end
			endcase
		end
	endfunction

	assign sel_ok   = in_bank(page_i, addr_i);
	assign sel_slot = slot_of(addr_i);
	assign wr_take  = wr_en_i && sel_ok;
	assign rd_take  = rd_en_i && sel_ok;

	// Each register sees its own strobe, and only for a hit on this bank
	always @* begin
		num0_hi_wr  = 1'b0;
		num0_lo_wr  = 1'b0;
		num1_hi_wr  = 1'b0;
		num1_lo_wr  = 1'b0;
		den1_hi_wr  = 1'b0;
		den1_lo_wr  = 1'b0;
		atten_hi_wr = 1'b0;
		atten_lo_wr = 1'b0;
		if (wr_take) begin
			case (sel_slot)
				SLOT_NUM0_HI: begin
					num0_hi_wr = 1'b1;
				end
				SLOT_NUM0_LO: begin
					num0_lo_wr = 1'b1;
				end
				SLOT_NUM1_HI: begin
					num1_hi_wr = 1'b1;
				end
				SLOT_NUM1_LO: begin
					num1_lo_wr = 1'b1;
				end
				SLOT_DEN1_HI: begin
					den1_hi_wr = 1'b1;
				end
				SLOT_DEN1_LO: begin
					den1_lo_wr = 1'b1;
				end
				SLOT_ATTEN_HI: begin
					atten_hi_wr = 1'b1;
				end
				SLOT_ATTEN_LO: begin
					atten_lo_wr = 1'b1;
				end
				default: begin
					num0_hi_wr = 1'b0;
				end
			endcase
		end
	end

	coeff_byte_reg #(
		.RESET_VALUE (`RDC_NUM0_HI_RST)
	) u_num0_hi (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.wr_en_i   (num0_hi_wr),
		.wr_data_i (wr_data_i),
		.value_o   (num0_hi_byte)
	);

	coeff_byte_reg #(
		.RESET_VALUE (`RDC_NUM0_LO_RST)
	) u_num0_lo (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.wr_en_i   (num0_lo_wr),
		.wr_data_i (wr_data_i),
		.value_o   (num0_lo_byte)
	);

	coeff_byte_reg #(
		.RESET_VALUE (`RDC_NUM1_HI_RST)
	) u_num1_hi (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.wr_en_i   (num1_hi_wr),
		.wr_data_i (wr_data_i),
		.value_o   (num1_hi_byte)
	);

	coeff_byte_reg #(
		.RESET_VALUE (`RDC_NUM1_LO_RST)
	) u_num1_lo (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.wr_en_i   (num1_lo_wr),
		.wr_data_i (wr_data_i),
		.value_o   (num1_lo_byte)
	);

	coeff_byte_reg #(
		.RESET_VALUE (`RDC_DEN1_HI_RST)
	) u_den1_hi (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.wr_en_i   (den1_hi_wr),
		.wr_data_i (wr_data_i),
		.value_o   (den1_hi_byte)
	);

	coeff_byte_reg #(
		.RESET_VALUE (`RDC_DEN1_LO_RST)
	) u_den1_lo (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.wr_en_i   (den1_lo_wr),
		.wr_data_i (wr_data_i),
		.value_o   (den1_lo_byte)
	);

	coeff_byte_reg #(
		.RESET_VALUE (`RDC_ATTEN_HI_RST)
	) u_atten_hi (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.wr_en_i   (atten_hi_wr),
		.wr_data_i (wr_data_i),
		.value_o   (atten_hi_byte)
	);

	coeff_byte_reg #(
		.RESET_VALUE (`RDC_ATTEN_LO_RST)
	) u_atten_lo (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.wr_en_i   (atten_lo_wr),
		.wr_data_i (wr_data_i),
		.value_o   (atten_lo_byte)
	);

	// Same-cycle write and read return the old byte, because the mux looks
	// at register outputs that change only at the edge taking the write
	always @* begin
		nxt_rd_hit  = rd_take;
		nxt_rd_data = 8'h00;
		if (rd_take) begin
			case (sel_slot)
				SLOT_NUM0_HI: begin
					nxt_rd_data = num0_hi_byte;
				end
				SLOT_NUM0_LO: begin
					nxt_rd_data = num0_lo_byte;
				end
				SLOT_NUM1_HI: begin
					nxt_rd_data = num1_hi_byte;
				end
				SLOT_NUM1_LO: begin
					nxt_rd_data = num1_lo_byte;
				end
				SLOT_DEN1_HI: begin
					nxt_rd_data = den1_hi_byte;
				end
				SLOT_DEN1_LO: begin
					nxt_rd_data = den1_lo_byte;
				end
				SLOT_ATTEN_HI: begin
					nxt_rd_data = atten_hi_byte;
				end
				SLOT_ATTEN_LO: begin
					nxt_rd_data = atten_lo_byte;
				end
				default: begin
					nxt_rd_data = 8'h00;
				end
			endcase
		end
	end

	// Registered read keeps the bus data glitch free; misses read zero
	always @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			rd_data_ff <= 8'h00;
			rd_hit_ff  <= 1'b0;
		end else begin
			rd_data_ff <= nxt_rd_data;
			rd_hit_ff  <= nxt_rd_hit;
		end
	end

	assign rd_data_o = rd_data_ff;
	assign rd_hit_o  = rd_hit_ff;

	// Filter sees a write on the very next cycle
	coeff_word_join u_num0 (
		.hi_i   (num0_hi_byte),
		.lo_i   (num0_lo_byte),
		.word_o (numerator_tap_zero_o)
	);

	coeff_word_join u_num1 (
		.hi_i   (num1_hi_byte),
		.lo_i   (num1_lo_byte),
		.word_o (numerator_tap_one_o)
	);

	coeff_word_join u_den1 (
		.hi_i   (den1_hi_byte),
		.lo_i   (den1_lo_byte),
		.word_o (denominator_tap_one_o)
	);

	coeff_word_join u_atten (
		.hi_i   (atten_hi_byte),
		.lo_i   (atten_lo_byte),
		.word_o (spatial_atten_o)
	);
endmodule

// ==== rdc_defs.vh ====
/*
 Constants for the right-channel de-emphasis and spatial attenuation
 coefficient bank: page number, register addresses, reset values.
 Assumes it is included once per file through its own guard.
*/
`ifndef RDC_DEFS_VH
`define RDC_DEFS_VH

`define RDC_PAGE              8'h01
`define RDC_BASE_ADDR         7'h2f
`define RDC_LAST_ADDR         7'h36
`define RDC_NUM0_HI_ADDR      7'h2f
`define RDC_NUM0_LO_ADDR      7'h30
`define RDC_NUM1_HI_ADDR      7'h31
`define RDC_NUM1_LO_ADDR      7'h32
`define RDC_DEN1_HI_ADDR      7'h33
`define RDC_DEN1_LO_ADDR      7'h34
`define RDC_ATTEN_HI_ADDR     7'h35
`define RDC_ATTEN_LO_ADDR     7'h36
`define RDC_NUM0_HI_RST       8'h39
`define RDC_NUM0_LO_RST       8'h55
`define RDC_NUM1_HI_RST       8'hf3
`define RDC_NUM1_LO_RST       8'h2d
`define RDC_DEN1_HI_RST       8'h53
`define RDC_DEN1_LO_RST       8'h7e
`define RDC_ATTEN_HI_RST      8'h7f
`define RDC_ATTEN_LO_RST      8'hff
`define RDC_REG_COUNT         8

`endif

// ==== coeff_byte_reg.v ====
/*
 One byte-wide software register with a fixed reset pattern.
 Assumes write strobe and data come from logic on the same clock.
*/
module coeff_byte_reg #(
	parameter [7:0] RESET_VALUE = 8'h00
) (
	input  wire       clk_sys_i,
	input  wire       rst_i,
	input  wire       wr_en_i,
	input  wire [7:0] wr_data_i,
	output wire [7:0] value_o
);
	reg [7:0] value_ff;

	always @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			value_ff <= RESET_VALUE;
		end else if (wr_en_i) begin
			value_ff <= wr_data_i;
		end
	end

	assign value_o = value_ff;
endmodule

// ==== coeff_word_join.v ====
/*
 Joins an upper and lower byte into one signed 16-bit coefficient.
 Assumes both bytes come straight from coefficient registers.
*/
module coeff_word_join (
	input  wire               [7:0]  hi_i,
	input  wire               [7:0]  lo_i,
	output wire signed        [15:0] word_o
);
	// Upper byte carries the sign bit, giving -32768 to +32767
	assign word_o = {hi_i, lo_i};
endmodule

// ==== rdc_props.sv ====
/* Port checker for the coefficient bank.
 Assumes it is bound to the bank top and shares its clock and reset. */
module rdc_props (
	input logic               clk_sys_i,
	input logic               rst_i,
	input logic        [7:0]  page_i,
	input logic        [6:0]  addr_i,
	input logic               wr_en_i,
	input logic        [7:0]  wr_data_i,
	input logic               rd_en_i,
	input logic        [7:0]  rd_data_o,
	input logic               rd_hit_o,
	input logic signed [15:0] numerator_tap_zero_o,
	input logic signed [15:0] numerator_tap_one_o,
	input logic signed [15:0] denominator_tap_one_o,
	input logic signed [15:0] spatial_atten_o
);
	wire hit = page_i == 8'h01 && addr_i >= 7'h2f && addr_i <= 7'h36;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	a_read_hit: assert property (rd_en_i && hit |=> rd_hit_o)
		else $error("read hit missing");
	a_miss_quiet: assert property (!(rd_en_i && hit) |=> !rd_hit_o && rd_data_o == 8'h00)
		else $error("idle read not quiet");
	a_hi_write: assert property (wr_en_i && hit && addr_i == 7'h2f |=>
		numerator_tap_zero_o[15:8] == $past(wr_data_i)) else $error("upper byte lost");
	a_lo_write: assert property (wr_en_i && hit && addr_i == 7'h36 |=>
		spatial_atten_o[7:0] == $past(wr_data_i)) else $error("lower byte lost");
	a_num0_reset: assert property ($fell(rst_i) |-> numerator_tap_zero_o == 16'h3955)
		else $error("tap zero reset");
	a_num1_reset: assert property ($fell(rst_i) |-> numerator_tap_one_o == 16'hf32d)
		else $error("tap one reset");
	a_den1_reset: assert property ($fell(rst_i) |-> denominator_tap_one_o == 16'h537e)
		else $error("denominator reset");
	a_atten_reset: assert property ($fell(rst_i) |-> spatial_atten_o == 16'h7fff)
		else $error("attenuation reset");
	a_miss_no_write: assert property (!(wr_en_i && hit) |=>
		$stable(numerator_tap_zero_o) && $stable(numerator_tap_one_o) &&
		$stable(denominator_tap_one_o) && $stable(spatial_atten_o))
		else $error("refused write changed a word");
endmodule

bind right_deemph_3d_coeff_regs rdc_props u_props (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
	.page_i(page_i), .addr_i(addr_i), .wr_en_i(wr_en_i), .wr_data_i(wr_data_i),
	.rd_en_i(rd_en_i), .rd_data_o(rd_data_o), .rd_hit_o(rd_hit_o),
	.numerator_tap_zero_o(numerator_tap_zero_o), .numerator_tap_one_o(numerator_tap_one_o),
	.denominator_tap_one_o(denominator_tap_one_o), .spatial_atten_o(spatial_atten_o));

// ==== right_deemph_3d_coeff_regs_test.sv ====
/* Self-checking bench for the coefficient bank against a byte model.
 Assumes the bank answers reads one cycle after the strobe edge. */
module right_deemph_3d_coeff_regs_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys_i = 0, rst_i = 1, wr_en_i = 0, rd_en_i = 0;
	logic [7:0] page_i = 0, wr_data_i = 0;
	logic [6:0] addr_i = 0;
	wire [7:0] rd_data_o;
	wire rd_hit_o;
	wire signed [15:0] w0, w1, w2, w3;
	int n_fail = 0, n_compared = 0, mdl[8];
	int rst_mdl[8] = '{'h39, 'h55, 'hf3, 'h2d, 'h53, 'h7e, 'h7f, 'hff};
	bit [31:0] s = 84;
	right_deemph_3d_coeff_regs dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .page_i(page_i),
		.addr_i(addr_i), .wr_en_i(wr_en_i), .wr_data_i(wr_data_i), .rd_en_i(rd_en_i),
		.rd_data_o(rd_data_o), .rd_hit_o(rd_hit_o), .numerator_tap_zero_o(w0),
		.numerator_tap_one_o(w1), .denominator_tap_one_o(w2), .spatial_atten_o(w3));
	always #2 clk_sys_i = ~clk_sys_i;
	function bit [31:0] xs();
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	task chk16(logic [15:0] g, logic [15:0] e);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task chk8(logic [7:0] g, logic [7:0] e);
		chk16({8'h00, g}, {8'h00, e});
	endtask
	task test_done;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task chk_words;
		chk16(w0, {mdl[0][7:0], mdl[1][7:0]});
		chk16(w1, {mdl[2][7:0], mdl[3][7:0]});
		chk16(w2, {mdl[4][7:0], mdl[5][7:0]});
		chk16(w3, {mdl[6][7:0], mdl[7][7:0]});
	endtask
	// Two cycles per access so a strobe is never set and cleared at one edge
	task op(bit w, bit r, logic [7:0] pg, logic [6:0] ad, logic [7:0] d);
		int k, e;
		bit h;
		@(posedge clk_sys_i);
		page_i <= pg;
		addr_i <= ad;
		wr_en_i <= w;
		rd_en_i <= r;
		wr_data_i <= d;
		@(posedge clk_sys_i);
		wr_en_i <= 0;
		rd_en_i <= 0;
		k = ad - 47;
		h = pg == 1 && k >= 0 && k < 8;
		e = h ? mdl[k] : 0;
		if (h && w) mdl[k] = d;
		#1;
		chk8(rd_data_o, r ? e[7:0] : 8'h00);
		chk8({7'h00, rd_hit_o}, {7'h00, r && h});
		chk_words;
	endtask
	initial begin
		bit [31:0] r;
		mdl = rst_mdl;
		repeat (6) @(posedge clk_sys_i);
		rst_i <= 0;
		for (int round = 0; round < 2; round++) begin
			for (int i = 0; i < 8; i++) op(0, 1, 8'h01, 7'h2f + i[6:0], 8'h00);
			repeat (80) begin
				r = xs();
				op(r[0], r[1], r[3:2] == 0 ? 8'h02 : 8'h01, 7'h2d + r[7:4] % 11, r[15:8]);
			end
			// Mid-run reset must bring back every reset byte, written or not
			@(posedge clk_sys_i);
			rst_i <= 1;
			mdl = rst_mdl;
			repeat (2) @(posedge clk_sys_i);
			#1;
			chk_words;
			chk8(rd_data_o, 8'h00);
			chk8({7'h00, rd_hit_o}, 8'h00);
			@(posedge clk_sys_i);
			rst_i <= 0;
		end
		test_done;
	end
endmodule
